// >>> rtl/nws_cfg.svh
// Offsets, field positions, reset values, codes and timing for the network send engine
`ifndef NWS_CFG_SVH
`define NWS_CFG_SVH

// =====================================================================
// Register byte offsets
`define NWS_OFF_CW0 7'h00
`define NWS_OFF_CW1 7'h04
`define NWS_OFF_CW2 7'h08
`define NWS_OFF_CW3 7'h0c
`define NWS_OFF_CW4 7'h10
`define NWS_OFF_SRC 7'h14
`define NWS_OFF_DST 7'h18
`define NWS_OFF_CMD 7'h1c
`define NWS_OFF_PORTS 7'h20
`define NWS_OFF_ISTAT 7'h24
`define NWS_OFF_IMASK 7'h28
`define NWS_OFF_OWN 7'h2c
`define NWS_OFF_UFIT 7'h30
`define NWS_OFF_UNET 7'h34
`define NWS_OFF_RESP0 7'h38
`define NWS_OFF_RESP1 7'h3c
`define NWS_OFF_RESP2 7'h40
`define NWS_OFF_RESP3 7'h44
`define NWS_OFF_KIND 7'h48

// =====================================================================
// Control word fields
`define NWS_CW3_RETRY 3:0
`define NWS_CW3_PORT 11:8
`define NWS_CW3_NORESP 15
`define NWS_WORDS_MIN 16'h0001
`define NWS_WORDS_MAX 16'h0100
`define NWS_PORT_MAX 4'h7
`define NWS_NODE_LOCAL 8'h00
`define NWS_NODE_MAXN 8'h3e
`define NWS_NODE_BCAST 8'hff
`define NWS_NET_LOCAL 7'h00

// =====================================================================
// Destination unit codes
`define NWS_UNIT_CPU 8'h00
`define NWS_UNIT_HOST 8'h01
`define NWS_UNIT_BUS_HI 4'h1
`define NWS_UNIT_INNER 8'he1
`define NWS_UNIT_NET 8'hfe

// =====================================================================
// Response codes and reset values
`define NWS_RC_OK 16'h0000
`define NWS_RC_PARAM 16'h1001
`define NWS_RC_SELF 16'h1002
`define NWS_RC_TMO 16'h0205
`define NWS_PORTS_RST 8'hff

// =====================================================================
// Timing
`define NWS_CLK_NS 100
`define NWS_STEP_NS 100000000
`define NWS_TMO_DEF_MS 2000
`define NWS_STEP_MS 100
`define NWS_TICK_CYCLES (`NWS_STEP_NS / `NWS_CLK_NS)
`define NWS_TMO_DEF_STEPS (`NWS_TMO_DEF_MS / `NWS_STEP_MS)

`endif

// >>> rtl/nws_pkg.sv
// Types shared by the network send engine
package nws_pkg;

  // =====================================================================
  // Engine states
  typedef enum logic [2:0] {
    NWS_IDLE,
    NWS_HDR,
    NWS_RD,
    NWS_LOAD,
    NWS_DATA,
    NWS_WAIT
  } nws_state_t;

  // =====================================================================
  // Destination unit classes
  typedef enum logic [2:0] {
    NWS_K_CPU,
    NWS_K_HOST_APP,
    NWS_K_BUS_UNIT,
    NWS_K_INNER,
    NWS_K_NET_UNIT,
    NWS_K_BAD
  } nws_kind_t;

endpackage

// >>> rtl/nws_top.sv
// Network word send engine with APB registers, memory read port and link port
`timescale 1ns/1ns
`include "nws_cfg.svh"

module nws_top import nws_pkg::*; #(
  parameter int NUM_UNITS = 4,
  parameter int TICK_CYCLES = `NWS_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [15:0] tx_data,
  output logic tx_last,
  output logic [2:0] tx_port,
  input wire logic rx_valid,
  input wire logic [2:0] rx_port,
  input wire logic [15:0] rx_code
);

  // =====================================================================
  // APB decode
  wire logic [6:0] a = paddr[6:0];
  wire logic setup = psel & ~penable;
  wire logic acc = psel & penable;
  wire logic hit = (paddr[31:7] == 25'h0) && (a[1:0] == 2'b00) && (a <= `NWS_OFF_KIND);
  wire logic wr = acc & pwrite & hit;
  wire logic wr_cmd = wr && (a == `NWS_OFF_CMD);
  wire logic wr_ist = wr && (a == `NWS_OFF_ISTAT);

  logic [15:0] cw0_reg, cw1_reg, cw2_reg, cw3_reg, cw4_reg, src_reg, dst_reg;
  logic [7:0] own_reg;
  logic [NUM_UNITS-1:0] ufit_reg;
  logic [31:0] unet_reg;
  logic [1:0] istat_reg, imask_reg;
  logic [7:0] enab_reg, err_reg;
  logic [15:0] code_reg [0:7];
  logic [31:0] prdata_reg;
  nws_kind_t kind_reg;
  logic [3:0] busno_reg;

  // =====================================================================
  // Local network from lowest fitted unit
  logic [6:0] unet_w [0:NUM_UNITS];
  logic [NUM_UNITS:0] seen_w;
  assign unet_w[0] = `NWS_NET_LOCAL;
  assign seen_w[0] = 1'b0;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
      wire logic take = ufit_reg[gi] & ~seen_w[gi];
      assign unet_w[gi+1] = take ? unet_reg[7*gi +: 7] : unet_w[gi];
      assign seen_w[gi+1] = seen_w[gi] | ufit_reg[gi];
    end
  endgenerate
  wire logic [6:0] local_net = unet_w[NUM_UNITS];

  // =====================================================================
  // Control block check
  wire logic [7:0] c_unit = cw2_reg[7:0];
  wire logic [7:0] c_node = cw2_reg[15:8];
  wire logic [6:0] c_net = cw1_reg[6:0];
  wire logic [3:0] c_port = cw3_reg[`NWS_CW3_PORT];
  wire logic c_bcast = (c_node == `NWS_NODE_BCAST);
  wire logic c_bus = (c_unit[7:4] == `NWS_UNIT_BUS_HI);
  nws_kind_t c_kind;
  always_comb begin
    if (c_unit == `NWS_UNIT_CPU) c_kind = NWS_K_CPU;
    else if (c_unit == `NWS_UNIT_HOST) c_kind = NWS_K_HOST_APP;
    else if (c_bus) c_kind = NWS_K_BUS_UNIT;
    else if (c_unit == `NWS_UNIT_INNER) c_kind = NWS_K_INNER;
    else if (c_unit == `NWS_UNIT_NET) c_kind = NWS_K_NET_UNIT;
    else c_kind = NWS_K_BAD;
  end
  // Network 00 selects the local one
  wire logic [6:0] c_net_res = (c_net == `NWS_NET_LOCAL) ? local_net : c_net;
  wire logic c_node_ok = c_bcast || (c_node <= `NWS_NODE_MAXN);
  // Node 00 is only meaningful together with network 00
  wire logic c_loc_ok = (c_node != `NWS_NODE_LOCAL) || (c_net == `NWS_NET_LOCAL);
  wire logic c_here = (c_node == `NWS_NODE_LOCAL) || (c_node == own_reg);
  wire logic c_self = (c_unit == `NWS_UNIT_CPU) && c_here && (c_net_res == local_net);
  wire logic c_words_ok = (cw0_reg >= `NWS_WORDS_MIN) && (cw0_reg <= `NWS_WORDS_MAX);
  wire logic c_port_ok = (c_port <= `NWS_PORT_MAX);
  wire logic c_param_ok = c_words_ok && c_port_ok && c_node_ok && c_loc_ok
    && (c_kind != NWS_K_BAD);
  // Broadcast never waits, whatever bit 15 says
  wire logic c_noresp = cw3_reg[`NWS_CW3_NORESP] | c_bcast;

  // =====================================================================
  // Engine state
  nws_state_t state_reg, state_next;
  logic [1:0] hidx_reg, hidx_next;
  logic [8:0] widx_reg, widx_next, wlast_reg;
  logic [3:0] try_reg, try_next, retry_reg;
  logic [2:0] port_reg;
  logic noresp_reg;
  logic [$clog2(TICK_CYCLES)-1:0] tick_reg, tick_next;
  logic [15:0] tmo_reg, step_reg, step_next, txd_reg, txd_next, madr_reg, fin_code;
  logic [15:0] hdr0_reg, hdr1_reg, hdr3_reg, sbase_reg, dbase_reg;
  logic fin, fin_err, refuse;
  logic [2:0] fin_port;

  wire logic go = wr_cmd & pwdata[0] & (state_reg == NWS_IDLE);
  wire logic tx_hs = tx_valid & tx_ready;
  wire logic [15:0] tmo_lim = (tmo_reg == 16'h0) ? 16'(`NWS_TMO_DEF_STEPS) : tmo_reg;
  wire logic tick_end = (tick_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
  wire logic tmo_hit = tick_end && (step_reg == tmo_lim - 16'h1);
  wire logic rsp_hit = rx_valid && (rx_port == port_reg);
  wire logic [15:0] hdr_w = (hidx_reg == 2'd0) ? hdr0_reg :
    (hidx_reg == 2'd1) ? hdr1_reg : (hidx_reg == 2'd2) ? dbase_reg : hdr3_reg;

  always_comb begin
    state_next = state_reg;
    hidx_next = hidx_reg;
    widx_next = widx_reg;
    try_next = try_reg;
    txd_next = txd_reg;
    step_next = step_reg;
    tick_next = tick_reg;
    fin = 1'b0;
    fin_err = 1'b0;
    fin_code = `NWS_RC_OK;
    fin_port = port_reg;
    refuse = 1'b0;
    unique case (state_reg)
      NWS_IDLE: begin
        if (go && (!c_param_ok || c_self)) begin
          refuse = 1'b1;
          fin = 1'b1;
          fin_err = 1'b1;
          fin_code = c_self ? `NWS_RC_SELF : `NWS_RC_PARAM;
          fin_port = c_port[2:0];
        end else if (go) begin
          state_next = NWS_HDR;
          hidx_next = 2'd0;
          widx_next = 9'd0;
          try_next = 4'd0;
          txd_next = {1'b0, 8'h0, c_net_res};
        end
      end
      NWS_HDR: begin
        if (tx_hs && hidx_reg == 2'd3) begin
          state_next = NWS_RD;
        end else if (tx_hs) begin
          hidx_next = hidx_reg + 2'd1;
          txd_next = (hidx_reg == 2'd0) ? hdr1_reg : (hidx_reg == 2'd1) ? dbase_reg : hdr3_reg;
        end else begin
          txd_next = hdr_w;
        end
      end
      NWS_RD: state_next = NWS_LOAD;
      NWS_LOAD: begin
        state_next = NWS_DATA;
        txd_next = mem_rdata;
      end
      NWS_DATA: begin
        if (tx_hs && widx_reg != wlast_reg) begin
          widx_next = widx_reg + 9'd1;
          state_next = NWS_RD;
        end else if (tx_hs && noresp_reg) begin
          state_next = NWS_IDLE;
          fin = 1'b1;
        end else if (tx_hs) begin
          state_next = NWS_WAIT;
          step_next = 16'h0;
          tick_next = '0;
        end
      end
      NWS_WAIT: begin
        tick_next = tick_end ? '0 : tick_reg + 1'b1;
        step_next = tick_end ? step_reg + 16'h1 : step_reg;
        if (rsp_hit) begin
          state_next = NWS_IDLE;
          fin = 1'b1;
          fin_code = rx_code;
          fin_err = (rx_code != `NWS_RC_OK);
        end else if (tmo_hit && try_reg < retry_reg) begin
          state_next = NWS_HDR;
          try_next = try_reg + 4'd1;
          hidx_next = 2'd0;
          widx_next = 9'd0;
          txd_next = hdr0_reg;
        end else if (tmo_hit) begin
          state_next = NWS_IDLE;
          fin = 1'b1;
          fin_err = 1'b1;
          fin_code = `NWS_RC_TMO;
        end
      end
      default: state_next = NWS_IDLE;
    endcase
  end

  // =====================================================================
  // Engine registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= NWS_IDLE;
      {hidx_reg, widx_reg, try_reg, txd_reg, step_reg, tick_reg, madr_reg} <= '0;
    end else begin
      state_reg <= state_next;
      hidx_reg <= hidx_next;
      widx_reg <= widx_next;
      try_reg <= try_next;
      txd_reg <= txd_next;
      step_reg <= step_next;
      tick_reg <= tick_next;
      madr_reg <= sbase_reg + 16'(widx_next);
    end
  end
  // Request is latched at acceptance so software may rewrite the block meanwhile
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      {port_reg, retry_reg, noresp_reg, tmo_reg, wlast_reg} <= '0;
      {hdr0_reg, hdr1_reg, hdr3_reg, sbase_reg, dbase_reg} <= '0;
    end else if (go && !refuse) begin
      port_reg <= c_port[2:0];
      retry_reg <= c_bcast ? 4'd0 : cw3_reg[`NWS_CW3_RETRY];
      noresp_reg <= c_noresp;
      tmo_reg <= cw4_reg;
      wlast_reg <= 9'(cw0_reg - 16'h1);
      hdr0_reg <= {1'b0, 8'h0, c_net_res};
      hdr1_reg <= cw2_reg;
      hdr3_reg <= {~c_noresp, c_port[2:0], 3'b000, 9'(cw0_reg - 16'h1)};
      sbase_reg <= src_reg;
      dbase_reg <= dst_reg;
    end
  end

  // =====================================================================
  // Port flags, response codes and decoded destination
  genvar gp;
  generate
    for (gp = 0; gp < 8; gp++) begin : g_port
      wire logic start = go && !refuse && (c_port[2:0] == gp);
      wire logic stop = fin && (fin_port == gp) && !(refuse && !c_port_ok);
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          enab_reg[gp] <= 1'b1;
          err_reg[gp] <= 1'b0;
          code_reg[gp] <= `NWS_RC_OK;
        end else if (start) begin
          enab_reg[gp] <= 1'b0;
          err_reg[gp] <= 1'b0;
          code_reg[gp] <= `NWS_RC_OK;
        end else if (stop) begin
          enab_reg[gp] <= 1'b1;
          err_reg[gp] <= fin_err;
          code_reg[gp] <= fin_code;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      kind_reg <= NWS_K_CPU;
      busno_reg <= 4'h0;
    end else if (go) begin
      kind_reg <= c_kind;
      busno_reg <= c_unit[3:0];
    end
  end

  // =====================================================================
  // Software registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      {cw0_reg, cw1_reg, cw2_reg, cw3_reg, cw4_reg, src_reg, dst_reg} <= '0;
      {own_reg, ufit_reg, unet_reg, imask_reg} <= '0;
    end else if (wr) begin
      if (a == `NWS_OFF_CW0) cw0_reg <= pwdata[15:0];
      if (a == `NWS_OFF_CW1) cw1_reg <= pwdata[15:0];
      if (a == `NWS_OFF_CW2) cw2_reg <= pwdata[15:0];
      if (a == `NWS_OFF_CW3) cw3_reg <= pwdata[15:0];
      if (a == `NWS_OFF_CW4) cw4_reg <= pwdata[15:0];
      if (a == `NWS_OFF_SRC) src_reg <= pwdata[15:0];
      if (a == `NWS_OFF_DST) dst_reg <= pwdata[15:0];
      if (a == `NWS_OFF_OWN) own_reg <= pwdata[7:0];
      if (a == `NWS_OFF_UFIT) ufit_reg <= pwdata[NUM_UNITS-1:0];
      if (a == `NWS_OFF_UNET) unet_reg <= pwdata;
      if (a == `NWS_OFF_IMASK) imask_reg <= pwdata[1:0];
    end
  end
  // Done in bit 0, abnormal end in bit 1; a new event beats a same-cycle clear
  wire logic [1:0] ev = {fin & fin_err, fin & ~fin_err};
  wire logic [1:0] iclr = wr_ist ? pwdata[1:0] : 2'b00;
  always_ff @(posedge mclk) istat_reg <= !reset_n ? 2'b00 : ((istat_reg & ~iclr) | ev);

  // =====================================================================
  // Read path: data captured in setup, shown in access
  wire logic [31:0] rd_w =
    (a == `NWS_OFF_CW0) ? {16'h0, cw0_reg} :
    (a == `NWS_OFF_CW1) ? {16'h0, cw1_reg} :
    (a == `NWS_OFF_CW2) ? {16'h0, cw2_reg} :
    (a == `NWS_OFF_CW3) ? {16'h0, cw3_reg} :
    (a == `NWS_OFF_CW4) ? {16'h0, cw4_reg} :
    (a == `NWS_OFF_SRC) ? {16'h0, src_reg} :
    (a == `NWS_OFF_DST) ? {16'h0, dst_reg} :
    (a == `NWS_OFF_PORTS) ? {15'h0, state_reg != NWS_IDLE, err_reg, enab_reg} :
    (a == `NWS_OFF_ISTAT) ? {30'h0, istat_reg} :
    (a == `NWS_OFF_IMASK) ? {30'h0, imask_reg} :
    (a == `NWS_OFF_OWN) ? {24'h0, own_reg} :
    (a == `NWS_OFF_UFIT) ? 32'(ufit_reg) :
    (a == `NWS_OFF_UNET) ? unet_reg :
    (a == `NWS_OFF_RESP0) ? {code_reg[1], code_reg[0]} :
    (a == `NWS_OFF_RESP1) ? {code_reg[3], code_reg[2]} :
    (a == `NWS_OFF_RESP2) ? {code_reg[5], code_reg[4]} :
    (a == `NWS_OFF_RESP3) ? {code_reg[7], code_reg[6]} :
    (a == `NWS_OFF_KIND) ? {16'h0, 1'b0, local_net, 1'b0, kind_reg, busno_reg} :
    32'h0;

  always_ff @(posedge mclk) begin
    if (!reset_n || setup) prdata_reg <= (reset_n && hit && !pwrite) ? rd_w : 32'h0;
  end

  // =====================================================================
  // Outputs
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign irq = |(istat_reg & imask_reg);
  assign mem_rd = (state_reg == NWS_RD);
  assign mem_addr = madr_reg;
  assign tx_valid = (state_reg == NWS_HDR) || (state_reg == NWS_DATA);
  assign tx_data = txd_reg;
  assign tx_last = (state_reg == NWS_DATA) && (widx_reg == wlast_reg);
  assign tx_port = port_reg;

endmodule // nws_top

// >>> verification/nws_properties.sv
// Checker for link-side timing and frame content of the send engine
`timescale 1ns/1ns
module nws_properties (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [15:0] tx_data,
  input wire logic tx_last,
  input wire logic [2:0] tx_port
);
  logic hs;
  logic seen_rd;
  logic [9:0] wcnt;
  logic [15:0] hdr1;
  logic [15:0] hdr3;
  logic [15:0] last_addr;
  assign hs = tx_valid && tx_ready;
  // ====
  // Word position within the current frame
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wcnt <= 10'h000;
      seen_rd <= 1'b0;
    end else begin
      if (hs) wcnt <= tx_last ? 10'h000 : wcnt + 10'h001;
      if (mem_rd || (hs && tx_last)) seen_rd <= mem_rd;
    end
  end
  always_ff @(posedge mclk) begin
    if (mem_rd) last_addr <= mem_addr;
    if (hs && wcnt == 10'h001) hdr1 <= tx_data;
    if (hs && wcnt == 10'h003) hdr3 <= tx_data;
  end
  // ====
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_read_then_offer: assert property (mem_rd |-> ##2 (tx_valid && !mem_rd))
    else $error("word not offered two cycles after read");
  a_data_copied: assert property (mem_rd |-> ##2 tx_data == $past(mem_rdata))
    else $error("offered word differs from memory data");
  a_addr_step: assert property (mem_rd && seen_rd |-> mem_addr == last_addr + 16'h0001)
    else $error("read address did not advance by one");
  a_offer_holds: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last) && $stable(tx_port))
    else $error("offered word changed before acceptance");
  a_frame_length: assert property (hs && tx_last |-> wcnt == {1'b0, hdr3[8:0]} + 10'h004)
    else $error("frame length differs from word count");
  a_bcast_quiet: assert property (hs && wcnt == 10'h003 && hdr1[15:8] == 8'hff
    |-> !tx_data[15])
    else $error("broadcast frame asks for a response");
  a_not_self: assert property (hs && wcnt == 10'h001 |-> tx_data != 16'h0000)
    else $error("frame addressed to own processor");
  a_node_range: assert property (hs && wcnt == 10'h001
    |-> (tx_data[15:8] <= 8'h3e || tx_data[15:8] == 8'hff))
    else $error("illegal node in frame");
  a_net_range: assert property (hs && wcnt == 10'h000 |-> tx_data[15:7] == 9'h000)
    else $error("network word out of range");
  c_frame_end: cover property (hs && tx_last);
  c_stall: cover property (tx_valid && !tx_ready);
  c_bcast: cover property (hs && wcnt == 10'h003 && hdr1[15:8] == 8'hff);
endmodule // nws_properties

bind nws_top nws_properties i_nws_properties (.mclk(mclk), .reset_n(reset_n),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_port(tx_port));

// >>> verification/nws_far_model.sv
// Far-side model: local memory read port and remote link end
`timescale 1ns/1ns
module nws_far_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic answer,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [15:0] mem_rdata,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic [2:0] tx_port,
  output logic tx_ready,
  output logic rx_valid,
  output logic [2:0] rx_port,
  output logic [15:0] rx_code
);
  logic [1:0] phase;
  logic [2:0] delay;
  // Data valid one cycle after the strobe, garbled otherwise
  always_ff @(posedge mclk) begin
    mem_rdata <= mem_rd ? {mem_addr[7:0], ~mem_addr[7:0]} : ~mem_rdata;
  end
  assign tx_ready = !slow || phase == 2'h3;
  assign rx_code = rx_valid ? 16'h0000 : 16'hffff;
  always_ff @(posedge mclk) begin
    rx_valid <= answer && delay == 3'h1;
    if (!reset_n) begin
      phase <= 2'h0;
      delay <= 3'h0;
    end else begin
      phase <= phase + 2'h1;
      if (tx_valid && tx_ready && tx_last) begin
        delay <= 3'h5;
        rx_port <= tx_port;
      end else if (delay != 3'h0) begin
        delay <= delay - 3'h1;
      end
    end
  end
endmodule // nws_far_model

// >>> verification/tb_nws_top.sv
// Testbench for the network send engine
`timescale 1ns/1ns
`include "nws_cfg.svh"
module tb_nws_top;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, irq, mem_rd, tx_valid;
  logic tx_ready, tx_last, rx_valid, slow, answer, se;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] mem_addr, mem_rdata, tx_data, rx_code;
  logic [2:0] tx_port, rx_port;
  logic [15:0] words[$];
  int err_count = 0, check_count = 0, frames = 0, cyc = 0, t0 = 0;
  nws_top #(.TICK_CYCLES(10)) i_nws_top (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .tx_port(tx_port), .rx_valid(rx_valid), .rx_port(rx_port),
    .rx_code(rx_code));
  nws_far_model i_nws_far_model (.mclk(mclk), .reset_n(reset_n), .slow(slow),
    .answer(answer), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_port(tx_port), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_port(rx_port), .rx_code(rx_code));
  // ====
  // Reporting
  task close_out;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (tx_valid && tx_ready) begin
      words.push_back(tx_data);
      if (tx_last) frames++;
    end
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end
  // ====
  // Bus and request helpers
  task apb(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {25'h0, a};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task send(input logic [15:0] c0, c1, c2, c3, c4, input logic acc);
    apb(1, `NWS_OFF_CW0, {16'h0, c0});
    apb(1, `NWS_OFF_CW1, {16'h0, c1});
    apb(1, `NWS_OFF_CW2, {16'h0, c2});
    apb(1, `NWS_OFF_CW3, {16'h0, c3});
    apb(1, `NWS_OFF_CW4, {16'h0, c4});
    apb(1, `NWS_OFF_SRC, 32'h40);
    apb(1, `NWS_OFF_DST, 32'h1234);
    words.delete();
    frames = 0;
    t0 = cyc;
    apb(1, `NWS_OFF_CMD, 32'h1);
    apb(0, `NWS_OFF_PORTS, 32'h0);
    if (acc) chk({rd[16], rd[c3[10:8]]}, 2'b10);
    rd = 32'h0;
    repeat (400) if (rd[1:0] == 2'b00) apb(0, `NWS_OFF_ISTAT, 32'h0);
  endtask
  // ====
  // Scenarios
  task t_send_ok;
    logic [15:0] e[$];
    e = {16'h0005, 16'h0510, 16'h1234, 16'ha002, 16'h40bf, 16'h41be, 16'h42bd};
    slow <= 1'b1;
    answer <= 1'b1;
    send(16'h3, 16'h0, 16'h0510, 16'h0201, 16'h0, 1'b1);
    chk(rd, 32'h1);
    chk(words.size(), e.size());
    foreach (e[i]) chk(words[i], e[i]);
    apb(0, `NWS_OFF_PORTS, 32'h0);
    chk(rd[16:0], 17'h000ff);
    chk(irq, 1'b0);
    apb(1, `NWS_OFF_IMASK, 32'h1);
    @(posedge mclk);
    chk(irq, 1'b1);
    apb(1, `NWS_OFF_ISTAT, 32'h1);
    @(posedge mclk);
    chk(irq, 1'b0);
    slow <= 1'b0;
    answer <= 1'b0;
  endtask
  task t_nowait(input logic [15:0] c2, c3);
    send(16'h1, 16'h0, c2, c3, 16'h1, 1'b1);
    repeat (100) @(posedge mclk);
    chk(rd[1:0], 2'b01);
    chk(frames, 1);
    chk(words[3], 16'h1000);
    apb(1, `NWS_OFF_ISTAT, 32'h3);
  endtask
  task t_timeout(input logic [15:0] c3, c4, input int nf, lo, hi);
    send(16'h2, 16'h0, 16'h0510, c3, c4, 1'b1);
    chk(rd[1:0], 2'b10);
    chk(frames, nf);
    chk(cyc - t0 >= lo && cyc - t0 <= hi, 1'b1);
    apb(0, `NWS_OFF_PORTS, 32'h0);
    chk({rd[11], rd[3]}, 2'b11);
    apb(0, `NWS_OFF_RESP1, 32'h0);
    chk(rd[31:16], 16'h0205);
    apb(1, `NWS_OFF_ISTAT, 32'h3);
  endtask
  task t_refuse;
    logic [15:0] c0 [6] = '{16'h0, 16'h101, 16'h1, 16'h1, 16'h1, 16'h1};
    logic [15:0] c2 [6] = '{16'h0510, 16'h0510, 16'h4010, 16'h0010, 16'h0, 16'h0100};
    logic [15:0] rc [6] = '{16'h1001, 16'h1001, 16'h1001, 16'h1001, 16'h1002, 16'h1002};
    for (int i = 0; i < 6; i++) begin
      send(c0[i], {15'h0, i == 3}, c2[i], 16'h0400, 16'h0, 1'b0);
      chk(rd[1:0], 2'b10);
      chk(frames, 0);
      apb(0, `NWS_OFF_RESP2, 32'h0);
      chk(rd[15:0], rc[i]);
      apb(1, `NWS_OFF_ISTAT, 32'h3);
    end
  endtask
  task t_kind;
    logic [7:0] u [7] = '{8'h00, 8'h01, 8'h10, 8'h1f, 8'he1, 8'hfe, 8'h02};
    logic [2:0] k [7] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5};
    // Port 8 is refused, so every start below leaves the port flags alone
    apb(1, `NWS_OFF_CW3, 32'h800);
    for (int i = 0; i < 7; i++) begin
      apb(1, `NWS_OFF_CW2, {24'h0, u[i]});
      apb(1, `NWS_OFF_CMD, 32'h1);
      apb(0, `NWS_OFF_KIND, 32'h0);
      chk(rd[14:4], {7'h05, 1'b0, k[i]});
      if (k[i] == 3'h2) chk(rd[3:0], u[i][3:0]);
    end
    apb(0, `NWS_OFF_PORTS, 32'h0);
    chk(rd[16:0], 17'h000ff);
    apb(0, `NWS_OFF_ISTAT, 32'h0);
    chk(rd[1:0], 2'b10);
    apb(1, `NWS_OFF_ISTAT, 32'h3);
  endtask
  initial begin
    {reset_n, psel, penable, pwrite, slow, answer} = 6'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    apb(1, `NWS_OFF_UFIT, 32'h6);
    apb(1, `NWS_OFF_UNET, 32'h18280);
    apb(1, `NWS_OFF_OWN, 32'h1);
    t_kind;
    t_send_ok;
    t_nowait(16'hfffe, 16'h0103);
    t_nowait(16'h0510, 16'h8103);
    t_timeout(16'h0302, 16'h1, 3, 40, 110);
    t_timeout(16'h0300, 16'h0, 1, 205, 245);
    t_refuse;
    apb(0, 6'h3f, 32'h0);
    chk(se, 1'b1);
    chk(rd, 32'h0);
    close_out;
  end
endmodule // tb_nws_top
